// ---- include/power_wake_pkg.sv ----
// Constants, types and register map of the power-state and wake controller.
package power_wake_pkg;
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  PWR_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  TEST_OFS        = 8'h04;
   localparam logic [7:0]  INTERRUPT_STATUS_REG_OFS     = 8'h08;
   localparam logic [7:0]  INT_EN_OFS      = 8'h0C;
   localparam logic [7:0]  PHY_CTRL_OFS    = 8'h10;
   localparam int          MODE_LSB        = 0;
   localparam int          READY_BIT       = 2;
   localparam int          SRC_LSB         = 4;
   localparam int          RXW_EN_BIT      = 8;
   localparam int          EDW_EN_BIT      = 9;
   localparam int          WOUT_EN_BIT     = 10;
   localparam int          PULSE_SEL_BIT   = 11;
   localparam int          INT_WAKE_BIT    = 0;
   localparam int          INT_ENERGY_BIT  = 1;
   localparam int          PHY_GPD_BIT     = 0;
   localparam int          PHY_EDPD_BIT    = 1;
   localparam int          PHY_ENERGY_BIT  = 2;
   localparam logic [1:0]  MODE_NORMAL     = 2'h0;
   localparam logic [1:0]  MODE_RX_SLEEP   = 2'h1;
   localparam logic [1:0]  MODE_ED_SLEEP   = 2'h2;
   localparam logic [1:0]  SRC_NONE        = 2'h0;
   localparam logic [1:0]  SRC_ENERGY      = 2'h1;
   localparam logic [1:0]  SRC_FRAME       = 2'h2;
   localparam logic [31:0] REG_RST         = 32'h0000_0000;
   localparam int          CLK_HZ          = 200_000_000;
   localparam int          CYCLES_PER_MS   = CLK_HZ / 1000;
   localparam int          PULSE_TIME_MS   = 50;
   localparam int          PULSE_CYCLES_DEF = PULSE_TIME_MS * CYCLES_PER_MS;
   localparam int          RESUME_LIMIT_MS = 2;
   localparam int          RESUME_MAX_CYCLES = RESUME_LIMIT_MS * CYCLES_PER_MS;
   localparam int          RESUME_CYCLES_DEF = 16;

   typedef enum logic [1:0] {ST_NORMAL, ST_RX_SLEEP, ST_ED_SLEEP, ST_RESUME} pwr_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;
endpackage

// ---- tb/power_state_wake_controller_tb.sv ----
// Self-checking testbench of the power-state and wake controller.
`timescale 1ns/10ps
module power_state_wake_controller_tb;
   import power_wake_pkg::*;
   localparam int unsigned PULSE = 20;
   logic        core_clk   = 1'b0;
   logic        srst       = 1'b1;
   reg_req_t    regReq     = '0;
   logic        frameGo    = 1'b0;
   logic [3:0]  frameDelay = 4'h0;
   logic        line_energy_sense   = 1'b0;
   logic [31:0] rngState   = 32'h0001_1CDB;
   logic [31:0] rdata;
   logic        wakeFrameDetect, lineEnergyPin, wakeOut, hostIrq, macClkEn;
   logic        hostIfClkEn, internalClkEn, rxWakeDetectEn, normalOperation;
   logic        phyPowerDown, phyEnergyMode, phyActive, phyTxInhibit, phyResetPulse;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          i;

   always #2.5 core_clk = ~core_clk;

   power_state_wake_controller #(.PULSE_CYCLES(PULSE), .RESUME_CYCLES(16))
      power_state_wake_controller_i
   (
      .core_clk        (core_clk),
      .srst            (srst),
      .regReq          (regReq),
      .rdata           (rdata),
      .wakeFrameDetect (wakeFrameDetect),
      .lineEnergyPin   (lineEnergyPin),
      .wakeOut         (wakeOut),
      .hostIrq         (hostIrq),
      .macClkEn        (macClkEn),
      .hostIfClkEn     (hostIfClkEn),
      .internalClkEn   (internalClkEn),
      .rxWakeDetectEn  (rxWakeDetectEn),
      .normalOperation (normalOperation),
      .phyPowerDown    (phyPowerDown),
      .phyEnergyMode   (phyEnergyMode),
      .phyActive       (phyActive),
      .phyTxInhibit    (phyTxInhibit),
      .phyResetPulse   (phyResetPulse)
   );

   wake_far_end wake_far_end_i
   (
      .core_clk        (core_clk),
      .frameGo         (frameGo),
      .frameDelay      (frameDelay),
      .line_energy_sense        (line_energy_sense),
      .wakeFrameDetect (wakeFrameDetect),
      .lineEnergyPin   (lineEnergyPin)
   );

   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] ctrl(input logic [1:0] m, input logic r,
                                        input logic [1:0] s, input logic [3:0] e);
      return {20'h0_0000, e, 2'h0, s, 1'b0, r, m};
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regReq.addr  <= a;
      regReq.wdata <= d;
      regReq.wr    <= 1'b1;
      @(posedge core_clk);
      regReq.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regReq.addr <= a;
      regReq.rd   <= 1'b1;
      @(posedge core_clk);
      regReq.rd <= 1'b0;
      #1;
   endtask

   task automatic waitReady();
      for (i = 0; i < 40; i++)
      begin
         rd(PWR_CTRL_OFS);
         if (rdata[READY_BIT] === 1'b1)
            break;
      end
      chk("ready", {31'h0, rdata[READY_BIT]}, 32'h1);
   endtask

   task automatic waitWake(input int lim);
      for (i = 0; i < lim && wakeOut !== 1'b1; i++)
         cyc(1);
   endtask

   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      wr(PWR_CTRL_OFS, 32'h0000_0F00);
      rd(PWR_CTRL_OFS);
      chk("ctrl resume", rdata, 32'h0);
      waitReady();
      rd(PWR_CTRL_OFS);
      chk("early write", rdata, ctrl(MODE_NORMAL, 1'b1, SRC_NONE, 4'h0));
      for (int k = 0; k < 8; k++)
      begin
         rngState = nextRand(rngState);
         wr(INT_EN_OFS, rngState);
         rd(INT_EN_OFS);
         chk("irq enable", rdata, rngState & 32'h3);
      end
      rd(8'hF0);
      chk("unmapped", rdata, 32'h0);
      $display("test reset done");

      wr(INT_EN_OFS, 32'h1);
      wr(PWR_CTRL_OFS, ctrl(MODE_RX_SLEEP, 1'b0, SRC_NONE, 4'h5));
      chk("rx clocks", {macClkEn, hostIfClkEn, internalClkEn, rxWakeDetectEn}, 32'h3);
      rd(INT_EN_OFS);
      chk("sleep read", rdata, 32'h0);
      rd(PWR_CTRL_OFS);
      chk("rx ctrl", rdata, ctrl(MODE_RX_SLEEP, 1'b0, SRC_NONE, 4'h5));
      rngState   = nextRand(rngState);
      frameDelay = rngState[3:0];
      @(posedge core_clk);
      frameGo <= 1'b1;
      @(posedge core_clk);
      frameGo <= 1'b0;
      waitWake(30);
      chk("rx wake out", wakeOut, 1'b1);
      cyc(2);
      chk("rx irq", hostIrq, 1'b1);
      rd(PWR_CTRL_OFS);
      chk("frame source", rdata, ctrl(MODE_RX_SLEEP, 1'b0, SRC_FRAME, 4'h5));
      rngState = nextRand(rngState);
      wr(TEST_OFS, rngState);
      rd(PWR_CTRL_OFS);
      chk("wake mode", rdata, ctrl(MODE_NORMAL, 1'b0, SRC_FRAME, 4'h5));
      waitReady();
      chk("static out", wakeOut, 1'b1);
      rd(INTERRUPT_STATUS_REG_OFS);
      chk("wake status", rdata, 32'h1);
      wr(INTERRUPT_STATUS_REG_OFS, 32'h1);
      rd(INTERRUPT_STATUS_REG_OFS);
      chk("status held", rdata, 32'h1);
      wr(PWR_CTRL_OFS, ctrl(MODE_NORMAL, 1'b0, SRC_NONE, 4'h5));
      cyc(1);
      chk("out cleared", wakeOut, 1'b0);
      wr(INTERRUPT_STATUS_REG_OFS, 32'h1);
      rd(INTERRUPT_STATUS_REG_OFS);
      chk("status cleared", rdata, 32'h0);
      $display("test rx sleep done");

      wr(PHY_CTRL_OFS, 32'h2);
      chk("ed idle", {phyEnergyMode, phyActive, phyTxInhibit}, 32'h5);
      wr(PWR_CTRL_OFS, ctrl(MODE_ED_SLEEP, 1'b0, SRC_NONE, 4'hE));
      chk("ed clocks", {hostIfClkEn, internalClkEn, macClkEn}, 32'h0);
      @(posedge core_clk);
      line_energy_sense <= 1'b1;
      waitWake(30);
      chk("ed wake out", wakeOut, 1'b1);
      chk("phy up", phyActive, 1'b1);
      for (i = 0; i < 100 && wakeOut === 1'b1; i++)
         cyc(1);
      chk("pulse length", i, PULSE);
      wr(TEST_OFS, 32'hFFFF_FFFF);
      waitReady();
      chk("not resumed", normalOperation, 1'b0);
      rd(PWR_CTRL_OFS);
      chk("energy source", rdata, ctrl(MODE_NORMAL, 1'b1, SRC_ENERGY, 4'hE));
      rd(INTERRUPT_STATUS_REG_OFS);
      chk("energy flag", rdata, 32'h3);
      wr(PHY_CTRL_OFS, 32'h0);
      // The pending flag drops one edge after the powerdown bit itself.
      cyc(1);
      chk("resumed", normalOperation, 1'b1);
      wr(PWR_CTRL_OFS, ctrl(MODE_NORMAL, 1'b0, SRC_NONE, 4'hE));
      wr(INTERRUPT_STATUS_REG_OFS, 32'h3);
      rd(INTERRUPT_STATUS_REG_OFS);
      chk("flags cleared", rdata, 32'h0);
      wr(PHY_CTRL_OFS, 32'h2);
      wr(PWR_CTRL_OFS, ctrl(MODE_ED_SLEEP, 1'b0, SRC_NONE, 4'h6));
      waitWake(10);
      chk("carrier at entry", wakeOut, 1'b1);
      wr(TEST_OFS, 32'h0);
      waitReady();
      wr(PWR_CTRL_OFS, ctrl(MODE_NORMAL, 1'b0, SRC_ENERGY, 4'h2));
      cyc(1);
      chk("out disabled", wakeOut, 1'b0);
      wr(PHY_CTRL_OFS, 32'h0);
      @(posedge core_clk);
      line_energy_sense <= 1'b0;
      $display("test energy sleep done");

      wr(PHY_CTRL_OFS, 32'h1);
      chk("phy down", {phyPowerDown, phyActive, phyTxInhibit}, 32'h5);
      wr(PHY_CTRL_OFS, 32'h0);
      chk("phy reset", phyResetPulse, 1'b1);
      cyc(1);
      chk("reset pulse end", phyResetPulse, 1'b0);
      $display("test phy powerdown done");
      complete_run();
   end
endmodule

// ---- tb/wake_far_end.sv ----
// Behavioural far side: MAC wake-frame detector and line energy sense.
`timescale 1ns/10ps
module wake_far_end
(
   input  wire logic       core_clk,
   input  wire logic       frameGo,
   input  wire logic [3:0] frameDelay,
   input  wire logic       line_energy_sense,
   output logic            wakeFrameDetect,
   output logic            lineEnergyPin
);
   initial
   begin
      wakeFrameDetect = 1'b0;
      lineEnergyPin   = 1'b0;
   end

   // A frame is reported after a chosen delay; the test sends only one frame, so one delay occurs per run.
   always @(posedge frameGo)
   begin
      repeat (frameDelay) @(posedge core_clk);
      wakeFrameDetect <= 1'b1;
      @(posedge core_clk);
      wakeFrameDetect <= 1'b0;
   end

   // Energy sense is not aligned to the core clock.
   always @(line_energy_sense)
      lineEnergyPin <= #1.3 line_energy_sense;
endmodule

// ---- verilog/power_state_wake_controller.sv ----
// Power-state sequencer, wake detection, wake output and transceiver power control.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module power_state_wake_controller
   import power_wake_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES  = PULSE_CYCLES_DEF,
   parameter int unsigned RESUME_CYCLES = RESUME_CYCLES_DEF
)
(
   input  wire logic  core_clk,
   input  wire logic  srst,
   input  wire reg_req_t regReq,
   output logic [31:0] rdata,
   input  wire logic  wakeFrameDetect,
   input  wire logic  lineEnergyPin,
   output logic       wakeOut,
   output logic       hostIrq,
   output logic       macClkEn,
   output logic       hostIfClkEn,
   output logic       internalClkEn,
   output logic       rxWakeDetectEn,
   output logic       normalOperation,
   output logic       phyPowerDown,
   output logic       phyEnergyMode,
   output logic       phyActive,
   output logic       phyTxInhibit,
   output logic       phyResetPulse
);
   if (RESUME_CYCLES < 1 || RESUME_CYCLES > 63 || RESUME_CYCLES > RESUME_MAX_CYCLES)
   begin : g_chk
      $error("RESUME_CYCLES must lie in 1..63 and within the resume limit");
   end

   pwr_state_t  state_reg,        state_next;
   logic        readSeen_reg,     readSeen_next;
   logic [5:0]  resumeCnt_reg,    resumeCnt_next;
   logic [1:0]  srcField_reg,     srcField_next;
   logic        rxWakeEn_reg,     rxWakeEn_next;
   logic        edWakeEn_reg,     edWakeEn_next;
   logic        wakeOutEn_reg,    wakeOutEn_next;
   logic        pulseSel_reg,     pulseSel_next;
   logic        intWake_reg,      intWake_next;
   logic        intEnergy_reg,    intEnergy_next;
   logic        intEnWake_reg,    intEnWake_next;
   logic        intEnEnergy_reg,  intEnEnergy_next;
   logic        gpd_reg,          gpd_next;
   logic        edpd_reg,         edpd_next;
   logic        edPending_reg,    edPending_next;
   logic        srcActDly_reg,    srcActDly_next;
   logic        energyPrev_reg,   energyPrev_next;
   logic        phyReset_reg,     phyReset_next;
   logic        wakeOut_reg,      wakeOut_next;
   logic        hostIrq_reg,      hostIrq_next;
   logic [31:0] rdata_reg,        rdata_next;
   logic [2:0]  energySync_reg;
   logic        energyLevel_reg;

   logic        ready;
   logic        asleep;
   logic        wrOk;
   logic        srcActive;
   logic        srcRise;
   logic        pulseActive;
   logic [1:0]  modeField;
   logic [31:0] ctrlView;

   // Three-stage synchroniser; the level moves only when stages two and three agree.
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         energySync_reg  <= 3'h0;
         energyLevel_reg <= 1'b0;
      end
      else
      begin
         energySync_reg <= {energySync_reg[1:0], lineEnergyPin};
         if (energySync_reg[1] == energySync_reg[2])
         begin
            energyLevel_reg <= energySync_reg[2];
         end
      end
   end

   assign ready  = (state_reg == ST_NORMAL);
   assign asleep = (state_reg == ST_RX_SLEEP) || (state_reg == ST_ED_SLEEP);
   assign wrOk   = regReq.wr && readSeen_reg && ready;

   always_comb
   begin
      unique case (state_reg)
         ST_RX_SLEEP: modeField = MODE_RX_SLEEP;
         ST_ED_SLEEP: modeField = MODE_ED_SLEEP;
         ST_NORMAL,
         ST_RESUME:   modeField = MODE_NORMAL;
      endcase
   end

   // The wake status and wake output follow the stored source and the matching enable.
   assign srcActive = ((srcField_reg == SRC_FRAME) && rxWakeEn_reg)
                   || ((srcField_reg == SRC_ENERGY) && edWakeEn_reg);
   assign srcRise   = srcActive && !srcActDly_reg;

   always_comb
   begin
      ctrlView = REG_RST;
      ctrlView[MODE_LSB +: 2]  = modeField;
      ctrlView[READY_BIT]      = ready;
      ctrlView[SRC_LSB +: 2]   = srcField_reg;
      ctrlView[RXW_EN_BIT]     = rxWakeEn_reg;
      ctrlView[EDW_EN_BIT]     = edWakeEn_reg;
      ctrlView[WOUT_EN_BIT]    = wakeOutEn_reg;
      ctrlView[PULSE_SEL_BIT]  = pulseSel_reg;
   end

   always_comb
   begin
      state_next       = state_reg;
      readSeen_next    = readSeen_reg;
      resumeCnt_next   = resumeCnt_reg;
      srcField_next    = srcField_reg;
      rxWakeEn_next    = rxWakeEn_reg;
      edWakeEn_next    = edWakeEn_reg;
      wakeOutEn_next   = wakeOutEn_reg;
      pulseSel_next    = pulseSel_reg;
      intEnWake_next   = intEnWake_reg;
      intEnEnergy_next = intEnEnergy_reg;
      gpd_next         = gpd_reg;
      edpd_next        = edpd_reg;
      edPending_next   = edPending_reg;
      intWake_next     = intWake_reg;
      intEnergy_next   = intEnergy_reg;
      rdata_next       = REG_RST;

      if (regReq.rd)
      begin
         readSeen_next = 1'b1;
         if (ready || regReq.addr == PWR_CTRL_OFS)
         begin
            unique case (regReq.addr)
               PWR_CTRL_OFS: rdata_next = ctrlView;
               INTERRUPT_STATUS_REG_OFS:
               begin
                  rdata_next[INT_WAKE_BIT]   = intWake_reg;
                  rdata_next[INT_ENERGY_BIT] = intEnergy_reg;
               end
               INT_EN_OFS:
               begin
                  rdata_next[INT_WAKE_BIT]   = intEnWake_reg;
                  rdata_next[INT_ENERGY_BIT] = intEnEnergy_reg;
               end
               PHY_CTRL_OFS:
               begin
                  rdata_next[PHY_GPD_BIT]    = gpd_reg;
                  rdata_next[PHY_EDPD_BIT]   = edpd_reg;
                  rdata_next[PHY_ENERGY_BIT] = energyLevel_reg;
               end
               default: rdata_next = REG_RST;
            endcase
         end
      end

      if (wrOk)
      begin
         unique case (regReq.addr)
            PWR_CTRL_OFS:
            begin
               srcField_next  = regReq.wdata[SRC_LSB +: 2];
               rxWakeEn_next  = regReq.wdata[RXW_EN_BIT];
               edWakeEn_next  = regReq.wdata[EDW_EN_BIT];
               wakeOutEn_next = regReq.wdata[WOUT_EN_BIT];
               pulseSel_next  = regReq.wdata[PULSE_SEL_BIT];
               if (regReq.wdata[MODE_LSB +: 2] == MODE_RX_SLEEP)
               begin
                  state_next = ST_RX_SLEEP;
               end
               else if (regReq.wdata[MODE_LSB +: 2] == MODE_ED_SLEEP)
               begin
                  state_next = ST_ED_SLEEP;
               end
            end
            INT_EN_OFS:
            begin
               intEnWake_next   = regReq.wdata[INT_WAKE_BIT];
               intEnEnergy_next = regReq.wdata[INT_ENERGY_BIT];
            end
            PHY_CTRL_OFS:
            begin
               gpd_next  = regReq.wdata[PHY_GPD_BIT];
               edpd_next = regReq.wdata[PHY_EDPD_BIT];
            end
            default:
            begin
            end
         endcase
      end

      if (!edpd_reg)
      begin
         edPending_next = 1'b0;
      end

      unique case (state_reg)
         ST_RX_SLEEP:
         begin
            if (wakeFrameDetect)
            begin
               srcField_next = SRC_FRAME;
            end
         end
         ST_ED_SLEEP:
         begin
            // A carrier already present is a level, so it is seen on the first cycle.
            if (energyLevel_reg)
            begin
               srcField_next = SRC_ENERGY;
            end
         end
         ST_RESUME:
         begin
            resumeCnt_next = resumeCnt_reg + 6'h01;
            if (resumeCnt_reg == 6'(RESUME_CYCLES - 1))
            begin
               state_next = ST_NORMAL;
            end
         end
         ST_NORMAL:
         begin
         end
      endcase

      if (asleep && regReq.wr && regReq.addr == TEST_OFS)
      begin
         state_next     = ST_RESUME;
         readSeen_next  = 1'b0;
         resumeCnt_next = 6'h00;
         edPending_next = (state_reg == ST_ED_SLEEP);
      end

      // Write-one clears, but an active wake source keeps the wake status set; the energy status is set only when the energy level rises.
      if (wrOk && regReq.addr == INTERRUPT_STATUS_REG_OFS && regReq.wdata[INT_WAKE_BIT])
      begin
         intWake_next = 1'b0;
      end
      if (wrOk && regReq.addr == INTERRUPT_STATUS_REG_OFS && regReq.wdata[INT_ENERGY_BIT])
      begin
         intEnergy_next = 1'b0;
      end
      if (srcActive)
      begin
         intWake_next = 1'b1;
      end
      if (energyLevel_reg && !energyPrev_reg && edpd_reg)
      begin
         intEnergy_next = 1'b1;
      end
   end

   assign srcActDly_next  = srcActive;
   assign energyPrev_next = energyLevel_reg;
   assign phyReset_next   = gpd_reg && !gpd_next;
   assign hostIrq_next    = (intWake_next && intEnWake_reg)
                         || (intEnergy_next && intEnEnergy_reg);
   // Static mode holds while the source stands; pulse mode also needs the timer.
   assign wakeOut_next    = wakeOutEn_reg && srcActive
                         && (!pulseSel_reg || pulseActive);

   wake_pulse_timer #(
      .COUNT (PULSE_CYCLES)
   ) u_pulse (
      .core_clk (core_clk),
      .srst     (srst),
      .start    (srcRise),
      .clear    (!srcActive),
      .active   (pulseActive)
   );

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_reg       <= ST_RESUME;
         readSeen_reg    <= 1'b0;
         resumeCnt_reg   <= 6'h00;
         srcField_reg    <= SRC_NONE;
         rxWakeEn_reg    <= 1'b0;
         edWakeEn_reg    <= 1'b0;
         wakeOutEn_reg   <= 1'b0;
         pulseSel_reg    <= 1'b0;
         intWake_reg     <= 1'b0;
         intEnergy_reg   <= 1'b0;
         intEnWake_reg   <= 1'b0;
         intEnEnergy_reg <= 1'b0;
         gpd_reg         <= 1'b0;
         edpd_reg        <= 1'b0;
         edPending_reg   <= 1'b0;
         srcActDly_reg   <= 1'b0;
         energyPrev_reg  <= 1'b0;
         phyReset_reg    <= 1'b0;
         wakeOut_reg     <= 1'b0;
         hostIrq_reg     <= 1'b0;
         rdata_reg       <= REG_RST;
      end
      else
      begin
         state_reg       <= state_next;
         readSeen_reg    <= readSeen_next;
         resumeCnt_reg   <= resumeCnt_next;
         srcField_reg    <= srcField_next;
         rxWakeEn_reg    <= rxWakeEn_next;
         edWakeEn_reg    <= edWakeEn_next;
         wakeOutEn_reg   <= wakeOutEn_next;
         pulseSel_reg    <= pulseSel_next;
         intWake_reg     <= intWake_next;
         intEnergy_reg   <= intEnergy_next;
         intEnWake_reg   <= intEnWake_next;
         intEnEnergy_reg <= intEnEnergy_next;
         gpd_reg         <= gpd_next;
         edpd_reg        <= edpd_next;
         edPending_reg   <= edPending_next;
         srcActDly_reg   <= srcActDly_next;
         energyPrev_reg  <= energyPrev_next;
         phyReset_reg    <= phyReset_next;
         wakeOut_reg     <= wakeOut_next;
         hostIrq_reg     <= hostIrq_next;
         rdata_reg       <= rdata_next;
      end
   end

   assign rdata           = rdata_reg;
   assign wakeOut         = wakeOut_reg;
   assign hostIrq         = hostIrq_reg;
   // The host interface clock stops in both sleep states; the wake write to TEST_OFS is still seen on core_clk.
   assign macClkEn        = ready;
   assign hostIfClkEn     = !asleep;
   assign internalClkEn   = (state_reg != ST_ED_SLEEP);
   assign rxWakeDetectEn  = (state_reg == ST_RX_SLEEP);
   assign normalOperation = ready && !edPending_reg;
   assign phyPowerDown    = gpd_reg;
   assign phyEnergyMode   = edpd_reg;
   assign phyActive       = !gpd_reg && (!edpd_reg || energyLevel_reg);
   assign phyTxInhibit    = !phyActive;
   assign phyResetPulse   = phyReset_reg;

   a_sleep_not_ready: assert property (@(posedge core_clk) disable iff (srst)
      asleep |-> (ctrlView[READY_BIT] == 1'b0 && !macClkEn))
      else $error("ready seen while asleep");

   a_sleep_read_zero: assert property (@(posedge core_clk) disable iff (srst)
      (regReq.rd && !ready && regReq.addr != PWR_CTRL_OFS) |=> (rdata == 32'h0000_0000))
      else $error("register other than power control answered while not ready");

   a_write_unread: assert property (@(posedge core_clk) disable iff (srst)
      (regReq.wr && !readSeen_reg && regReq.addr == PWR_CTRL_OFS)
      |=> $stable(ctrlView[PULSE_SEL_BIT:SRC_LSB]))
      else $error("write took effect before any read");

   a_wake_exit: assert property (@(posedge core_clk) disable iff (srst)
      (asleep && regReq.wr && regReq.addr == TEST_OFS)
      |=> (state_reg == ST_RESUME && modeField == MODE_NORMAL && !readSeen_reg))
      else $error("test register write did not wake the device");

   a_ready_time: assert property (@(posedge core_clk) disable iff (srst)
      (state_reg == ST_RESUME && $past(asleep)) |-> ##[1:64] ready)
      else $error("ready not set in time after wake");

   a_frame_source: assert property (@(posedge core_clk) disable iff (srst)
      (state_reg == ST_RX_SLEEP && wakeFrameDetect) |=> (srcField_reg == SRC_FRAME))
      else $error("frame detect did not set the wake source");

   a_energy_source: assert property (@(posedge core_clk) disable iff (srst)
      (state_reg == ST_ED_SLEEP && energyLevel_reg) |=> (srcField_reg == SRC_ENERGY))
      else $error("carrier did not set the wake source");

   a_int_held: assert property (@(posedge core_clk) disable iff (srst)
      srcActive |=> intWake_reg)
      else $error("wake status clear while its source stands");

   a_wake_drop: assert property (@(posedge core_clk) disable iff (srst)
      (!wakeOutEn_reg || !srcActive) |=> !wakeOut)
      else $error("wake output active without source and enable");

   a_static_wake: assert property (@(posedge core_clk) disable iff (srst)
      (wakeOutEn_reg && srcActive && !pulseSel_reg) [*2] |-> wakeOut)
      else $error("static wake output not driven");
endmodule

// ---- verilog/wake_pulse_timer.sv ----
// Down-counter that holds the wake output pulse for a fixed number of cycles.
`timescale 1ns/10ps
module wake_pulse_timer
   import power_wake_pkg::*;
#(
   parameter int unsigned COUNT = PULSE_CYCLES_DEF
)
(
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic start,
   input  wire logic clear,
   output logic      active
);
   localparam int W = $clog2(COUNT + 1);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   if (COUNT < 1)
   begin : g_chk
      $error("wake_pulse_timer: COUNT must be at least one");
   end

   always_comb
   begin
      count_next = count_reg;
      if (clear)
      begin
         count_next = '0;
      end
      else if (start)
      begin
         count_next = W'(COUNT);
      end
      else if (count_reg != '0)
      begin
         count_next = count_reg - W'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign active = (count_reg != '0);

   a_pulse_load: assert property (@(posedge core_clk) disable iff (srst)
      (start && !clear) |=> (count_reg == W'(COUNT)))
      else $error("pulse timer did not load its full count");
endmodule
